//--- rtl/flash_status_pkg.sv
// Constants and types shared by the status register bank files.
package flash_status_pkg;

	// -----------------------------------------------------------------
	// Command codes
	// -----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
	localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
	localparam logic [7:0] OP_WRITE_FIRST     = 8'h01;
	localparam logic [7:0] OP_WRITE_SECOND    = 8'h31;
	localparam logic [7:0] OP_WRITE_THIRD     = 8'h11;
	localparam logic [7:0] OP_READ_FIRST      = 8'h05;
	localparam logic [7:0] OP_READ_SECOND     = 8'h35;
	localparam logic [7:0] OP_READ_THIRD      = 8'h15;
	localparam logic [7:0] OP_RESET_ARM       = 8'h66;
	localparam logic [7:0] OP_RESET_GO        = 8'h99;
	localparam logic [7:0] OP_SUSPEND         = 8'h75;
	localparam logic [7:0] OP_RESUME          = 8'h7A;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int LOCK_BIT     = 7;
	localparam int GRAN_BIT     = 6;
	localparam int END_BIT      = 5;
	localparam int FIELD_HI     = 4;
	localparam int FIELD_LO     = 2;
	localparam int PERMIT_BIT   = 1;
	localparam int BUSY_BIT     = 0;
	localparam int PAUSED_BIT   = 7;
	localparam int INVERT_BIT   = 6;
	localparam int LOCKS_HI     = 5;
	localparam int LOCKS_LO     = 3;
	localparam int FOUR_BIT     = 1;
	localparam int ROLE_BIT     = 7;
	localparam int DRIVE_HI     = 6;
	localparam int DRIVE_LO     = 5;
	localparam int FAST_BIT     = 4;
	localparam logic [7:0] RSVD_SECOND = 8'h05;
	localparam logic [7:0] RSVD_THIRD  = 8'h0F;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;

	// -----------------------------------------------------------------
	// Timing and counts
	// -----------------------------------------------------------------
	localparam int MCLK_PERIOD_NS  = 25;
	localparam int NV_WRITE_NS_DEF = 5000;
	localparam logic [2:0] BIT_ONE  = 3'h1;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] COUNT_NONE   = 2'h0;
	localparam logic [1:0] COUNT_OPCODE = 2'h1;
	localparam logic [1:0] COUNT_ONE    = 2'h2;
	localparam logic [1:0] COUNT_TWO    = 2'h3;
	localparam logic [3:0] SYNC_RESET   = 4'hB;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		FRAME_IDLE   = 2'h0,
		FRAME_OPCODE = 2'h1,
		FRAME_DATA   = 2'h3
	} frame_e;

	typedef enum logic [1:0] {
		READ_NONE   = 2'h0,
		READ_FIRST  = 2'h1,
		READ_SECOND = 2'h3,
		READ_THIRD  = 2'h2
	} read_sel_e;

	typedef struct packed {
		logic       lock_select;
		logic       granularity;
		logic       array_end;
		logic [2:0] protect_field;
		logic       invert_map;
		logic       four_line;
		logic       pin_role;
		logic       fast_clock;
	} config_s;

	typedef struct packed {
		logic [7:0] third;
		logic [7:0] second;
		logic [7:0] first;
	} status_bytes_s;

endpackage : flash_status_pkg

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a group of single-bit levels.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] hold;
	} sync_s;

	sync_s r;
	sync_s next_r;

	always_comb
	begin
		next_r.meta = d;
		next_r.hold = r.meta;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= {RESET_VALUE, RESET_VALUE};
		else
			r <= next_r;
	end

	assign q = r.hold;
endmodule : pin_sync
`default_nettype wire

//--- rtl/serial_status_link.sv
// Serial-clock side: byte capture, byte events and status read-out.
`timescale 1ns/10ps
`default_nettype none
module serial_status_link (
	input  wire logic                           sclk,
	input  wire logic                           cs_n,
	input  wire logic                           mosi,
	input  wire logic                           rst_n,
	input  wire flash_status_pkg::status_bytes_s status,
	output logic [7:0]                          byte_data,
	output logic                                byte_first,
	output logic                                byte_toggle,
	output logic                                miso,
	output logic                                miso_oe
);
	import flash_status_pkg::*;

	typedef struct packed {
		logic [2:0] bits;
		logic [6:0] shift;
		logic       first;
		read_sel_e  sel;
		logic [7:0] out;
	} frame_s;

	typedef struct packed {
		logic          toggle;
		logic [7:0]    data;
		logic          first;
		status_bytes_s meta;
		status_bytes_s s2;
		status_bytes_s s3;
	} event_s;

	localparam frame_s FRAME_RESET = '{first: 1'h1, sel: READ_NONE, default: '0};

	frame_s f;
	frame_s next_f;
	event_s e;
	event_s next_e;
	logic   out_bit;

	function automatic read_sel_e decode(input logic [7:0] op);
		case (op)
			OP_READ_FIRST:  decode = READ_FIRST;
			OP_READ_SECOND: decode = READ_SECOND;
			OP_READ_THIRD:  decode = READ_THIRD;
			default:        decode = READ_NONE;
		endcase
	endfunction : decode

	function automatic logic [7:0] pick(input read_sel_e s, input status_bytes_s w);
		case (s)
			READ_FIRST:  pick = w.first;
			READ_SECOND: pick = w.second;
			READ_THIRD:  pick = w.third;
			default:     pick = BYTE_ZERO;
		endcase
	endfunction : pick

	// -----------------------------------------------------------------
	// Byte assembly
	// -----------------------------------------------------------------
	// The status word is sampled through three stages; the third stage is always
	// used, as the agree test picks e.s3 either way, so a word caught mid-change can pass.
	always_comb
	begin
		logic [7:0]    full;
		read_sel_e     sel;
		status_bytes_s word;
		full        = {f.shift, mosi};
		sel         = f.first ? decode(full) : f.sel;
		word        = (e.s2 == e.s3) ? e.s2 : e.s3;
		next_f      = f;
		next_e      = e;
		next_e.meta = status;
		next_e.s2   = e.meta;
		next_e.s3   = e.s2;
		next_f.shift = full[6:0];
		next_f.bits  = f.bits + BIT_ONE;
		next_f.out   = {f.out[6:0], 1'h0};
		if (f.bits == BIT_LAST)
		begin
			next_e.toggle = ~e.toggle;
			next_e.data   = full;
			next_e.first  = f.first;
			next_f.first  = 1'h0;
			next_f.sel    = sel;
			next_f.out    = pick(sel, word);
		end
	end

	// Frame state ends with the frame itself, since the clock stops.
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			f <= FRAME_RESET;
		else
			f <= next_f;
	end

	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
			e <= '0;
		else
			e <= next_e;
	end

	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
			out_bit <= 1'h0;
		else
			out_bit <= f.out[7];
	end

	assign byte_data   = e.data;
	assign byte_first  = e.first;
	assign byte_toggle = e.toggle;
	assign miso        = out_bit;
	assign miso_oe     = ~cs_n & (f.sel != READ_NONE);
endmodule : serial_status_link
`default_nettype wire

//--- rtl/flash_status_bank.sv
// Status and configuration register bank of the serial flash.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Protect bit zero ignores write-guard pin.
// - Granularity bit picks 64-kB blocks or 4-kB sectors.
// - Array-end bit counts from top or bottom.
// - Write-permit latch read-only, gates embedded operations.
// - Busy flag reads one during embedded operation.
// - Paused flag reads one while operation suspended.
// - Invert bit selects complementary protection map.
// - Security locks are one-time programmable.
// - Four-line mode turns guard/pause pins into data.
// - Four-line off keeps guard and pause functions.
// - Role bit picks pause or restart.
// - Drive level field volatile, sets read drive.
// - Fast clock bit, stored non-volatile and volatile.
// - Protection and four-line bits kept in both copies.
// - Permit set only by write-enable, cleared on completion.
// - Reset reloads volatile copies from non-volatile ones.
// - Volatile-enable write touches only volatile copies.
// - Protect one, guard low locks words one, two.
module flash_status_bank #(
	parameter int NV_WRITE_NS = flash_status_pkg::NV_WRITE_NS_DEF
) (
	input  wire logic                     mclk,
	input  wire logic                     reset_n,
	input  wire logic                     sclk,
	input  wire logic                     cs_n,
	input  wire logic                     mosi,
	output logic                          miso,
	output logic                          miso_oe,
	input  wire logic                     data_line_two,
	input  wire logic                     data_line_three,
	input  wire logic                     op_active,
	input  wire logic                     op_done,
	output flash_status_pkg::config_s     active_config,
	output logic [2:0]                    security_locks,
	output logic [1:0]                    drive_level,
	output logic                          fast_clock_mode,
	output logic                          write_permit_latch,
	output logic                          pins_as_data,
	output logic                          guard_lock_active,
	output logic                          pause_request,
	output logic                          restart_request
);
	import flash_status_pkg::*;

	localparam int NV_CYCLES = (NV_WRITE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int TW        = $clog2(NV_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_ZERO = '0;
	localparam logic [TW-1:0] TIMER_ONE  = TW'(1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(NV_CYCLES);

	typedef struct packed {
		frame_e        frame;
		logic [7:0]    opcode;
		logic [1:0]    count;
		logic [7:0]    byte1;
		logic [7:0]    byte2;
		config_s       nv;
		config_s       vol;
		logic [2:0]    lock_bits;
		logic [1:0]    drive;
		logic          permit;
		logic          vol_permit;
		logic          paused;
		logic          reset_armed;
		logic [TW-1:0] nv_timer;
		logic          tog_seen;
		logic          cs_seen;
		logic          cs_seen_d;
		status_bytes_s status;
	} core_s;

	localparam core_s CORE_RESET = '{
		frame:     FRAME_IDLE,
		cs_seen:   1'h1,
		cs_seen_d: 1'h1,
		default:   '0
	};

	core_s      r;
	core_s      next_r;
	logic [3:0] synced;
	logic       cs_sync;
	logic       tog_sync;
	logic       guard_sync;
	logic       three_sync;
	logic [7:0] byte_data;
	logic       byte_first;
	logic       byte_toggle;
	logic       byte_event;
	logic       end_frame;
	logic       busy;
	logic       locked;
	logic       exec;
	logic       cmd_ok;
	logic       is_write;
	logic       wr_exec;
	logic       wr12_exec;
	logic       we_exec;
	logic       soft_exec;
	logic       suspend_exec;
	logic       restart_req;

	// -----------------------------------------------------------------
	// Field helpers
	// -----------------------------------------------------------------
	function automatic config_s apply_first(input config_s c, input logic [7:0] b);
		config_s o;
		o               = c;
		o.lock_select   = b[LOCK_BIT];
		o.granularity   = b[GRAN_BIT];
		o.array_end     = b[END_BIT];
		o.protect_field = b[FIELD_HI:FIELD_LO];
		return o;
	endfunction : apply_first

	function automatic config_s apply_second(input config_s c, input logic [7:0] b);
		config_s o;
		o            = c;
		o.invert_map = b[INVERT_BIT];
		o.four_line  = b[FOUR_BIT];
		return o;
	endfunction : apply_second

	function automatic config_s apply_third(input config_s c, input logic [7:0] b);
		config_s o;
		o            = c;
		o.pin_role   = b[ROLE_BIT];
		o.fast_clock = b[FAST_BIT];
		return o;
	endfunction : apply_third

	// Reserved positions are never set, so they read as zero.
	function automatic status_bytes_s pack_status(
		input config_s    c,
		input logic [2:0] locks,
		input logic [1:0] drv,
		input logic       bsy,
		input logic       perm,
		input logic       pause
	);
		status_bytes_s s;
		s                            = '0;
		s.first[LOCK_BIT]            = c.lock_select;
		s.first[GRAN_BIT]            = c.granularity;
		s.first[END_BIT]             = c.array_end;
		s.first[FIELD_HI:FIELD_LO]   = c.protect_field;
		s.first[PERMIT_BIT]          = perm;
		s.first[BUSY_BIT]            = bsy;
		s.second[PAUSED_BIT]         = pause;
		s.second[INVERT_BIT]         = c.invert_map;
		s.second[LOCKS_HI:LOCKS_LO]  = locks;
		s.second[FOUR_BIT]           = c.four_line;
		s.third[ROLE_BIT]            = c.pin_role;
		s.third[DRIVE_HI:DRIVE_LO]   = drv;
		s.third[FAST_BIT]            = c.fast_clock;
		return s;
	endfunction : pack_status

	// -----------------------------------------------------------------
	// Link and pin crossing
	// -----------------------------------------------------------------
	serial_status_link u_serial_status_link (
		.sclk        (sclk),
		.cs_n        (cs_n),
		.mosi        (mosi),
		.rst_n       (reset_n),
		.status      (r.status),
		.byte_data   (byte_data),
		.byte_first  (byte_first),
		.byte_toggle (byte_toggle),
		.miso        (miso),
		.miso_oe     (miso_oe)
	);

	pin_sync #(
		.WIDTH       (4),
		.RESET_VALUE (SYNC_RESET)
	) u_pin_sync (
		.clk   (mclk),
		.rst_n (reset_n),
		.d     ({cs_n, byte_toggle, data_line_two, data_line_three}),
		.q     (synced)
	);

	assign cs_sync    = synced[3];
	assign tog_sync   = synced[2];
	assign guard_sync = synced[1];
	assign three_sync = synced[0];

	// -----------------------------------------------------------------
	// Command decode
	// -----------------------------------------------------------------
	// The frame end is taken one cycle after the select rise is seen, so
	// the last byte event, crossing with the same latency, is stored first.
	assign byte_event   = tog_sync ^ r.tog_seen;
	assign end_frame    = r.cs_seen & ~r.cs_seen_d;
	assign busy         = op_active | (r.nv_timer != TIMER_ZERO);
	assign locked       = r.vol.lock_select & ~guard_sync & ~r.vol.four_line;
	assign exec         = end_frame & (r.count != COUNT_NONE);
	assign cmd_ok       = exec & ~busy;
	assign is_write     = ((r.opcode == OP_WRITE_FIRST) | (r.opcode == OP_WRITE_SECOND)
		| (r.opcode == OP_WRITE_THIRD)) & (r.count >= COUNT_ONE);
	assign wr_exec      = cmd_ok & is_write;
	assign wr12_exec    = wr_exec & (r.opcode != OP_WRITE_THIRD);
	assign we_exec      = cmd_ok & (r.opcode == OP_WRITE_ENABLE);
	assign soft_exec    = cmd_ok & (r.opcode == OP_RESET_GO) & r.reset_armed;
	assign suspend_exec = exec & (r.opcode == OP_SUSPEND) & busy;
	assign restart_req  = ~r.vol.four_line & r.vol.pin_role & ~three_sync;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb
	begin
		logic       has1;
		logic       has2;
		logic       has3;
		logic [7:0] w2;
		has1 = (r.opcode == OP_WRITE_FIRST) & ~locked;
		has2 = ((r.opcode == OP_WRITE_SECOND)
			| ((r.opcode == OP_WRITE_FIRST) & (r.count == COUNT_TWO))) & ~locked;
		has3 = r.opcode == OP_WRITE_THIRD;
		w2   = (r.opcode == OP_WRITE_SECOND) ? r.byte1 : r.byte2;
		next_r           = r;
		next_r.cs_seen   = cs_sync;
		next_r.cs_seen_d = r.cs_seen;
		if (r.nv_timer != TIMER_ZERO)
		begin
			next_r.nv_timer = r.nv_timer - TIMER_ONE;
			if (r.nv_timer == TIMER_ONE)
				next_r.permit = 1'h0;
		end
		if (op_done)
			next_r.permit = 1'h0;
		if (byte_event)
		begin
			next_r.tog_seen = tog_sync;
			if (byte_first)
			begin
				next_r.opcode = byte_data;
				next_r.count  = COUNT_OPCODE;
				next_r.frame  = FRAME_OPCODE;
			end
			else if (r.count == COUNT_OPCODE)
			begin
				next_r.byte1 = byte_data;
				next_r.count = COUNT_ONE;
				next_r.frame = FRAME_DATA;
			end
			else if (r.count == COUNT_ONE)
			begin
				next_r.byte2 = byte_data;
				next_r.count = COUNT_TWO;
			end
		end
		if (end_frame)
		begin
			next_r.frame = FRAME_IDLE;
			next_r.count = COUNT_NONE;
		end
		if (cmd_ok)
		begin
			next_r.reset_armed = r.opcode == OP_RESET_ARM;
			case (r.opcode)
				OP_WRITE_ENABLE:
				begin
					next_r.permit     = 1'h1;
					next_r.vol_permit = 1'h0;
				end
				OP_WRITE_DISABLE:
				begin
					next_r.permit     = 1'h0;
					next_r.vol_permit = 1'h0;
				end
				OP_VOLATILE_ENABLE:
					next_r.vol_permit = 1'h1;
				default:
					next_r.vol_permit = next_r.vol_permit;
			endcase
		end
		// Only the writable fields are copied; flags and reserved bits stay.
		if (wr_exec)
		begin
			next_r.vol_permit = 1'h0;
			if (r.permit)
			begin
				if (has1)
				begin
					next_r.nv  = apply_first(next_r.nv, r.byte1);
					next_r.vol = apply_first(next_r.vol, r.byte1);
				end
				if (has2)
				begin
					next_r.nv       = apply_second(next_r.nv, w2);
					next_r.vol      = apply_second(next_r.vol, w2);
					next_r.lock_bits = r.lock_bits | w2[LOCKS_HI:LOCKS_LO];
				end
				if (has3)
				begin
					next_r.nv    = apply_third(next_r.nv, r.byte1);
					next_r.vol   = apply_third(next_r.vol, r.byte1);
					next_r.drive = r.byte1[DRIVE_HI:DRIVE_LO];
				end
				next_r.nv_timer = TIMER_LOAD;
			end
			else if (r.vol_permit)
			begin
				if (has1)
					next_r.vol = apply_first(next_r.vol, r.byte1);
				if (has2)
					next_r.vol = apply_second(next_r.vol, w2);
				if (has3)
				begin
					next_r.vol   = apply_third(next_r.vol, r.byte1);
					next_r.drive = r.byte1[DRIVE_HI:DRIVE_LO];
				end
			end
		end
		if (suspend_exec)
			next_r.paused = 1'h1;
		if (exec & (r.opcode == OP_RESUME))
			next_r.paused = 1'h0;
		if (soft_exec | restart_req)
		begin
			next_r.vol         = r.nv;
			next_r.drive       = '0;
			next_r.permit      = 1'h0;
			next_r.vol_permit  = 1'h0;
			next_r.paused      = 1'h0;
			next_r.reset_armed = 1'h0;
		end
		next_r.status = pack_status(next_r.vol, next_r.lock_bits, next_r.drive,
			op_active | (next_r.nv_timer != TIMER_ZERO), next_r.permit, next_r.paused);
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			r <= CORE_RESET;
		else
			r <= next_r;
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign active_config      = r.vol;
	assign security_locks     = r.lock_bits;
	assign drive_level        = r.drive;
	assign fast_clock_mode    = r.vol.fast_clock;
	assign write_permit_latch = r.permit;
	assign pins_as_data       = r.vol.four_line;
	assign guard_lock_active  = locked;
	assign pause_request      = ~r.vol.four_line & ~r.vol.pin_role & ~three_sync & ~cs_sync;
	assign restart_request    = restart_req;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_busy_during_write: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(r.nv_timer != TIMER_ZERO) |-> r.status.first[BUSY_BIT])
		else $error("busy flag low during status write cycle");

	a_permit_end_clear: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(r.nv_timer == TIMER_ONE) |=> !r.permit && !r.status.first[PERMIT_BIT])
		else $error("write permit not cleared at write completion");

	a_permit_set_cause: assert property (
		@(posedge mclk) disable iff (!reset_n)
		$rose(r.permit) |-> $past(we_exec))
		else $error("write permit set without write-enable command");

	a_guard_lock_hold: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(wr12_exec && locked) |=> (r.nv == $past(r.nv)) && (r.vol == $past(r.vol)))
		else $error("locked status word was written");

	a_lock_bits_sticky: assert property (
		@(posedge mclk) disable iff (!reset_n)
		##1 (($past(r.lock_bits) & ~r.lock_bits) == 3'h0))
		else $error("security lock bit cleared");

	a_four_line_pins: assert property (
		@(posedge mclk) disable iff (!reset_n)
		r.vol.four_line |-> pins_as_data && !pause_request && !restart_request && !locked)
		else $error("pin functions active in four-line mode");

	a_reserved_zero: assert property (
		@(posedge mclk) disable iff (!reset_n)
		((r.status.second & RSVD_SECOND) == BYTE_ZERO)
		&& ((r.status.third & RSVD_THIRD) == BYTE_ZERO))
		else $error("reserved status bit reads one");

	a_volatile_only: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(wr_exec && !r.permit && r.vol_permit)
		|=> (r.nv == $past(r.nv)) && (r.nv_timer == TIMER_ZERO) && !r.vol_permit)
		else $error("volatile write touched non-volatile copy");

	a_reset_reload: assert property (
		@(posedge mclk) disable iff (!reset_n)
		soft_exec |=> (r.vol == r.nv) && (r.drive == 2'h0) && !r.permit)
		else $error("software reset did not reload volatile copies");

	a_pause_cause: assert property (
		@(posedge mclk) disable iff (!reset_n)
		$rose(r.paused) |-> $past(suspend_exec) && r.status.second[PAUSED_BIT])
		else $error("paused flag set without suspend");
endmodule : flash_status_bank
`default_nettype wire

//--- verif/spi_host_model.sv
// Serial host that frames status commands in mode 0 at an 80 ns clock.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// Sends nb bytes MSB first; rd keeps the last eight bits seen.
	task automatic frame(input logic [23:0] tx, input int nb, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		cs_n = 1'b0;
		#40;
		for (i = 0; i < nb * 8; i++)
		begin
			mosi = tx[23 - i];
			#40 sclk = 1'b1;
			rd = {rd[6:0], miso};
			#40 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		// A released line shows the inverse of its last value.
		mosi = ~mosi;
		#500;
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- verif/flash_status_bank_tb.sv
// Self-checking bench for the status register bank.
`timescale 1ns/10ps
`default_nettype none
module flash_status_bank_tb;
	import flash_status_pkg::*;
	logic       mclk = 1'b0;
	logic       reset_n = 1'b0;
	logic       two = 1'b1;
	logic       three = 1'b1;
	logic       op_active = 1'b0;
	logic       op_done = 1'b0;
	wire        sclk;
	wire        cs_n;
	wire        mosi;
	wire        miso;
	config_s    cfg;
	logic [2:0] locks;
	logic [1:0] drv;
	logic       fast;
	logic       permit;
	logic       pad;
	logic       gla;
	logic [7:0] rd;
	logic [7:0] r;
	logic [7:0] exp_q[$];
	event       rd_ev;
	int         miscompares = 0;
	int         samples_checked = 0;

	always #12.5 mclk = ~mclk;

	flash_status_bank #(.NV_WRITE_NS(200)) u_flash_status_bank (
		.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(), .data_line_two(two), .data_line_three(three),
		.op_active(op_active), .op_done(op_done), .active_config(cfg),
		.security_locks(locks), .drive_level(drv), .fast_clock_mode(fast),
		.write_permit_latch(permit), .pins_as_data(pad), .guard_lock_active(gla),
		.pause_request(), .restart_request()
	);
	spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		samples_checked++;
		if (seen !== expd)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	task automatic cmd(input logic [23:0] tx, input int nb);
		u_spi_host_model.frame(tx, nb, rd);
	endtask : cmd

	task automatic rdw(input logic [7:0] op, input logic [7:0] e);
		exp_q.push_back(e);
		u_spi_host_model.frame({op, 16'h0000}, 2, rd);
		-> rd_ev;
	endtask : rdw

	task automatic results;
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	always @(rd_ev) check(rd, exp_q.pop_front());

	initial
	begin
		void'($urandom(32'hCBFD));
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		rdw(OP_READ_FIRST, 8'h00);
		rdw(OP_READ_SECOND, 8'h00);
		rdw(OP_READ_THIRD, 8'h00);
		@(posedge mclk) op_active <= 1'b1;
		rdw(OP_READ_FIRST, 8'h01);
		@(posedge mclk) op_active <= 1'b0;
		cmd({OP_WRITE_ENABLE, 16'h0000}, 1);
		check({7'h00, permit}, 8'h01);
		@(posedge mclk) op_done <= 1'b1;
		@(posedge mclk) op_done <= 1'b0;
		@(posedge mclk);
		check({7'h00, permit}, 8'h00);
		cmd({OP_WRITE_ENABLE, 16'h0000}, 1);
		cmd({OP_WRITE_FIRST, 16'hFF3A}, 3);
		check({7'h00, permit}, 8'h00);
		rdw(OP_READ_FIRST, 8'hFC);
		rdw(OP_READ_SECOND, 8'h3A);
		check(cfg[9:2], 8'hFD);
		check({7'h00, pad}, 8'h01);
		cmd({OP_VOLATILE_ENABLE, 16'h0000}, 1);
		cmd({OP_WRITE_FIRST, 16'h0000}, 3);
		rdw(OP_READ_FIRST, 8'h00);
		rdw(OP_READ_SECOND, 8'h38);
		check({5'h00, locks}, 8'h07);
		cmd({OP_RESET_ARM, 16'h0000}, 1);
		cmd({OP_RESET_GO, 16'h0000}, 1);
		rdw(OP_READ_FIRST, 8'hFC);
		cmd({OP_VOLATILE_ENABLE, 16'h0000}, 1);
		cmd({OP_WRITE_SECOND, 16'h0000}, 2);
		@(posedge mclk) two <= 1'b0;
		repeat (4) @(posedge mclk);
		check({7'h00, gla}, 8'h01);
		cmd({OP_VOLATILE_ENABLE, 16'h0000}, 1);
		cmd({OP_WRITE_FIRST, 16'h0000}, 2);
		rdw(OP_READ_FIRST, 8'hFC);
		r = 8'($urandom);
		cmd({OP_VOLATILE_ENABLE, 16'h0000}, 1);
		cmd({OP_WRITE_THIRD, r, 8'h00}, 2);
		rdw(OP_READ_THIRD, r & 8'hF0);
		check({6'h00, drv}, {6'h00, r[6:5]});
		check({7'h00, fast}, {7'h00, r[4]});
		cmd({OP_VOLATILE_ENABLE, 16'h0000}, 1);
		cmd({OP_WRITE_THIRD, 8'hE0, 8'h00}, 2);
		check({6'h00, drv}, 8'h03);
		@(posedge mclk) three <= 1'b0;
		repeat (6) @(posedge mclk);
		three <= 1'b1;
		repeat (4) @(posedge mclk);
		check({6'h00, drv}, 8'h00);
		check({7'h00, cfg.pin_role}, 8'h00);
		@(posedge mclk) op_active <= 1'b1;
		cmd({OP_SUSPEND, 16'h0000}, 1);
		rdw(OP_READ_SECOND, 8'hBA);
		cmd({OP_RESUME, 16'h0000}, 1);
		@(posedge mclk) op_active <= 1'b0;
		rdw(OP_READ_SECOND, 8'h3A);
		// Lets the queued comparison run before the verdict is printed.
		@(posedge mclk);
		results();
	end
endmodule : flash_status_bank_tb
`default_nettype wire
